// ==== include/trig_pkg.sv ====
// Constants for the backplane trigger drive and monitor block
// =====================================================================
// Operation
// - Writing 1 to a TTL drive bit (15-8) asserts that TTL line.
// - Writing 1 to an ECL drive bit (1-0) asserts that ECL line.
// - Hard reset clears all drive bits; soft reset leaves them alone.
// - Drive register at offset 26 hex, write-only, 16 or 8-bit writes.
// - Status register at offset 28 hex, read-only, 16 or 8-bit reads.
// - Status reserved bits 15-8, 5-4, 1-0 read as 1.
// - Status bits 7-6 show live ECL line state, 1 means asserted.
// - Status bit 2 shows live front-panel trigger output level.
// - Read at 26 hex returns TTL line states high, logical address low.
package trig_pkg;
  localparam int ADDR_W = 6;
  localparam logic [5:0] OFS_DRIVE = 6'h26;
  localparam logic [5:0] OFS_STATUS = 6'h28;
  localparam int DRV_TTL_HI = 15;
  localparam int DRV_TTL_LO = 8;
  localparam int DRV_ECL_HI = 1;
  localparam int DRV_ECL_LO = 0;
  localparam logic [7:0] DRIVE_TTL_RESET = 8'h00;
  localparam logic [1:0] DRIVE_ECL_RESET = 2'h0;
  localparam int ST_ECL_HI = 7;
  localparam int ST_ECL_LO = 6;
  localparam int ST_IN_POS = 3;
  localparam int ST_OUT_POS = 2;
  localparam logic [15:0] STATUS_RSVD = 16'hff33;
endpackage

// ==== src/trigger_drive_monitor.sv ====
// Trigger drive register and trigger line status register
`timescale 1ns/10ps
module trigger_drive_monitor (
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic SOFT_RST,
  input wire logic [trig_pkg::ADDR_W-1:0] ADDR,
  input wire logic WR_EN,
  input wire logic RD_EN,
  input wire logic [1:0] BYTE_EN,
  input wire logic [15:0] WDATA,
  output logic [15:0] RDATA,
  output logic RVALID,
  input wire logic [7:0] LOGICAL_ADDRESS_BITS,
  input wire logic [7:0] TTL_LINE_STATE,
  input wire logic [1:0] ECL_LINE_STATE,
  input wire logic FRONT_INPUT_LEVEL,
  input wire logic FRONT_OUTPUT_LEVEL,
  output logic [7:0] TTL_DRIVE_BITS,
  output logic [1:0] ECL_DRIVE_BITS
);
  import trig_pkg::*;

  typedef struct packed {
    // Pin synchronisers, first and second flop
    logic [7:0] ttl0;
    logic [7:0] ttl1;
    logic [1:0] ecl0;
    logic [1:0] ecl1;
    logic in0;
    logic in1;
    logic out0;
    logic out1;
    // Drive registers, cleared only by hard reset
    logic [7:0] ttl_drv;
    logic [1:0] ecl_drv;
    // Registered read answer
    logic [15:0] rdata;
    logic rvalid;
  } state_s;

  state_s st_q;
  state_s st_d;
  logic [15:0] status_word;
  logic [15:0] addr_word;

  // =====================================================================
  // Read words built from second synchroniser stage; logical address bits read straight from the pins
  always_comb begin
    // Reserved status bits read as ones; live bits overlay them
    status_word = STATUS_RSVD;
    status_word[ST_ECL_HI:ST_ECL_LO] = st_q.ecl1;
    status_word[ST_IN_POS] = st_q.in1;
    status_word[ST_OUT_POS] = st_q.out1;
    addr_word = {st_q.ttl1, LOGICAL_ADDRESS_BITS};
  end

  // =====================================================================
  // Next state
  always_comb begin
    st_d = st_q;
    // Two flops on every line and front-panel pin before the read words use it; logical address bits get none
    st_d.ttl0 = TTL_LINE_STATE;
    st_d.ttl1 = st_q.ttl0;
    st_d.ecl0 = ECL_LINE_STATE;
    st_d.ecl1 = st_q.ecl0;
    st_d.in0 = FRONT_INPUT_LEVEL;
    st_d.in1 = st_q.in0;
    st_d.out0 = FRONT_OUTPUT_LEVEL;
    st_d.out1 = st_q.out0;
    st_d.rvalid = 1'b0;
    // Soft reset does not touch the drive bits
    // Each byte lane loads only its own drive bits
    if (WR_EN && ADDR == OFS_DRIVE) begin
      if (BYTE_EN[1]) begin
        st_d.ttl_drv = WDATA[DRV_TTL_HI:DRV_TTL_LO];
      end
      if (BYTE_EN[0]) begin
        st_d.ecl_drv = WDATA[DRV_ECL_HI:DRV_ECL_LO];
      end
    end
    // Read answer is registered and flagged valid for one cycle
    if (RD_EN) begin
      st_d.rvalid = 1'b1;
      if (ADDR == OFS_STATUS) begin
        st_d.rdata = status_word;
      end else if (ADDR == OFS_DRIVE) begin
        st_d.rdata = addr_word;
      end else begin
        st_d.rdata = 16'h0000;
      end
      // Unselected byte lanes read as zero
      if (!BYTE_EN[1]) begin
        st_d.rdata[15:8] = 8'h00;
      end
      if (!BYTE_EN[0]) begin
        st_d.rdata[7:0] = 8'h00;
      end
    end
  end

  // Hard reset only; soft reset never reaches this state
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st_q <= '0;
      st_q.ttl_drv <= DRIVE_TTL_RESET;
      st_q.ecl_drv <= DRIVE_ECL_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign TTL_DRIVE_BITS = st_q.ttl_drv;
  assign ECL_DRIVE_BITS = st_q.ecl_drv;
  assign RDATA = st_q.rdata;
  assign RVALID = st_q.rvalid;

  // =====================================================================
  // Assertions
  a_ttl_write: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    WR_EN && ADDR == OFS_DRIVE && BYTE_EN[1] |=> TTL_DRIVE_BITS ==
    $past(WDATA[15:8])) else $error("ttl drive not loaded");
  a_ecl_write: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    WR_EN && ADDR == OFS_DRIVE && BYTE_EN[0] |=> ECL_DRIVE_BITS ==
    $past(WDATA[1:0])) else $error("ecl drive not loaded");
  a_soft_keep: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    SOFT_RST && !WR_EN |=> $stable(TTL_DRIVE_BITS) &&
    $stable(ECL_DRIVE_BITS)) else $error("soft reset changed drive");
  a_drive_hold: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    !(WR_EN && ADDR == OFS_DRIVE) |=> $stable(TTL_DRIVE_BITS) &&
    $stable(ECL_DRIVE_BITS)) else $error("drive changed without write");
  a_wo_other: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    WR_EN && ADDR == OFS_STATUS |=> $stable(TTL_DRIVE_BITS))
    else $error("status write hit drive");
  a_status_rsvd: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    RD_EN && ADDR == OFS_STATUS && BYTE_EN == 2'h3 |=>
    (RDATA & STATUS_RSVD) == STATUS_RSVD) else $error("reserved not ones");

  // =====================================================================
  // Read path assertions
  // Line status lags the pins by the two synchroniser stages, so a read
  // within two cycles of reset release still shows the cleared stages
  a_status_ecl: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    RD_EN && ADDR == OFS_STATUS && BYTE_EN[0] && !$past(SYS_RST) &&
    !$past(SYS_RST, 2) |=>
    RDATA[7:6] == $past(ECL_LINE_STATE, 3)) else $error("ecl status bad");
  a_status_in: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    RD_EN && ADDR == OFS_STATUS && BYTE_EN[0] && !$past(SYS_RST) &&
    !$past(SYS_RST, 2) |=>
    RDATA[3] == $past(FRONT_INPUT_LEVEL, 3)) else $error("input bad");
  a_status_out: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    RD_EN && ADDR == OFS_STATUS && BYTE_EN[0] && !$past(SYS_RST) &&
    !$past(SYS_RST, 2) |=>
    RDATA[2] == $past(FRONT_OUTPUT_LEVEL, 3)) else $error("output bad");
  a_addr_read: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    RD_EN && ADDR == OFS_DRIVE && BYTE_EN == 2'h3 && !$past(SYS_RST) &&
    !$past(SYS_RST, 2) |=>
    RDATA == {$past(TTL_LINE_STATE, 3), $past(LOGICAL_ADDRESS_BITS)})
    else $error("address read bad");
  a_addr_high: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    RD_EN && ADDR == OFS_DRIVE && BYTE_EN == 2'h2 && !$past(SYS_RST) &&
    !$past(SYS_RST, 2) |=>
    RDATA == {$past(TTL_LINE_STATE, 3), 8'h00})
    else $error("ttl line byte read bad");
  a_addr_low: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    RD_EN && ADDR == OFS_DRIVE && BYTE_EN == 2'h1 |=>
    RDATA == {8'h00, $past(LOGICAL_ADDRESS_BITS)})
    else $error("address byte read bad");
  a_rvalid_one: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    RVALID |=> !RVALID || $past(RD_EN)) else $error("rvalid stuck");
  a_rvalid_read: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    RD_EN |=> RVALID) else $error("read not answered");
  a_rvalid_idle: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    !RD_EN |=> !RVALID) else $error("rvalid without read");
  a_rdata_hold: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    !RD_EN |=> $stable(RDATA)) else $error("read data moved");
  a_hole_zero: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    RD_EN && ADDR != OFS_STATUS && ADDR != OFS_DRIVE |=> RDATA == 16'h0000)
    else $error("unmapped read not zero");
  a_lane_hi: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    RD_EN && !BYTE_EN[1] |=> RDATA[15:8] == 8'h00)
    else $error("unselected high lane not zero");
  a_lane_lo: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    RD_EN && !BYTE_EN[0] |=> RDATA[7:0] == 8'h00)
    else $error("unselected low lane not zero");
  a_status_hi: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    RD_EN && ADDR == OFS_STATUS && BYTE_EN[1] |=> RDATA[15:8] == 8'hff)
    else $error("status high byte not ones");
  a_status_lo: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    RD_EN && ADDR == OFS_STATUS && BYTE_EN[0] |=> RDATA[5:4] == 2'h3 &&
    RDATA[1:0] == 2'h3) else $error("status low reserved not ones");

  // =====================================================================
  // Reset and write path assertions
  a_wo_ecl: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    WR_EN && ADDR != OFS_DRIVE |=> $stable(TTL_DRIVE_BITS) &&
    $stable(ECL_DRIVE_BITS)) else $error("stray write hit drive");
  a_ttl_lane: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    WR_EN && ADDR == OFS_DRIVE && !BYTE_EN[1] |=> $stable(TTL_DRIVE_BITS))
    else $error("ttl drive moved on low byte write");
  a_ecl_lane: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    WR_EN && ADDR == OFS_DRIVE && !BYTE_EN[0] |=> $stable(ECL_DRIVE_BITS))
    else $error("ecl drive moved on high byte write");
  a_ttl_free: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    WR_EN && ADDR == OFS_DRIVE && BYTE_EN[1] && WDATA[15:8] == 8'h00 |=>
    TTL_DRIVE_BITS == 8'h00) else $error("ttl line not released");
  a_ecl_free: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    WR_EN && ADDR == OFS_DRIVE && BYTE_EN[0] && WDATA[1:0] == 2'h0 |=>
    ECL_DRIVE_BITS == 2'h0) else $error("ecl line not released");
  a_hard_clear: assert property (@(posedge CLOCK) $fell(SYS_RST) |->
    TTL_DRIVE_BITS == 8'h00 && ECL_DRIVE_BITS == 2'h0 && !RVALID)
    else $error("hard reset left drive on");

  // =====================================================================
  // Scenario covers
  c_ttl_drive: cover property (@(posedge CLOCK) disable iff (SYS_RST)
    WR_EN && ADDR == OFS_DRIVE && BYTE_EN == 2'h3 && WDATA[15:8] != 8'h00);
  c_byte_write: cover property (@(posedge CLOCK) disable iff (SYS_RST)
    WR_EN && ADDR == OFS_DRIVE && BYTE_EN == 2'h1);
  c_status_read: cover property (@(posedge CLOCK) disable iff (SYS_RST)
    RD_EN && ADDR == OFS_STATUS ##1 RVALID && RDATA[7:6] != 2'h0);
  c_soft_reset: cover property (@(posedge CLOCK) disable iff (SYS_RST)
    SOFT_RST && TTL_DRIVE_BITS != 8'h00);
  c_addr_read: cover property (@(posedge CLOCK) disable iff (SYS_RST)
    RD_EN && ADDR == OFS_DRIVE ##1 RVALID && RDATA[15:8] != 8'h00);
endmodule

// ==== tb/test_trigger_drive_monitor.sv ====
// Self-checking bench for the trigger drive and monitor block
`timescale 1ns/10ps
module test_trigger_drive_monitor;
  import trig_pkg::*;
  logic clk = 0, rst = 1, srst = 0, wr = 0, rd = 0, rv, ti = 0, to = 0;
  logic [5:0] adr = 0;
  logic [1:0] be = 0, ex = 0, es, ed, b, e;
  logic [7:0] la = 8'h5a, tx = 0, ts, td, t;
  logic [15:0] wd = 0, rdat, d;
  int failures = 0, checks_done = 0;
  logic [27:0] rows [4] = '{{2'h3, 16'h0a03, 8'h0a, 2'h3},
    {2'h2, 16'h5500, 8'h55, 2'h3}, {2'h1, 16'h0001, 8'h55, 2'h1},
    {2'h3, 16'hff00, 8'hff, 2'h0}};
  always #2 clk = ~clk;
  trigger_drive_monitor trigger_drive_monitor_inst (.CLOCK(clk),
    .SYS_RST(rst), .SOFT_RST(srst), .ADDR(adr), .WR_EN(wr), .RD_EN(rd),
    .BYTE_EN(be), .WDATA(wd), .RDATA(rdat), .RVALID(rv),
    .LOGICAL_ADDRESS_BITS(la), .TTL_LINE_STATE(ts), .ECL_LINE_STATE(es),
    .FRONT_INPUT_LEVEL(ti), .FRONT_OUTPUT_LEVEL(to), .TTL_DRIVE_BITS(td),
    .ECL_DRIVE_BITS(ed));
  trig_lines trig_lines_inst (.ttl_drv(td), .ecl_drv(ed), .ttl_ext(tx),
    .ecl_ext(ex), .ttl_st(ts), .ecl_st(es));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic [5:0] a, input logic [1:0] m,
    input logic w, input logic [15:0] v);
    @(posedge clk) #1;
    adr = a;
    be = m;
    wd = v;
    wr = w;
    rd = !w;
    @(posedge clk) #1;
    wr = 0;
    rd = 0;
  endtask
  task automatic rdc(input logic [5:0] a, input logic [1:0] m,
    input logic [15:0] v);
    acc(a, m, 0, 0);
    chk({15'h0, rv}, 16'h1);
    chk(rdat, v);
  endtask
  function automatic logic [15:0] st(input logic [1:0] c);
    return STATUS_RSVD | {8'h0, c, 2'h0, ti, to, 2'h0};
  endfunction
  task automatic end_sim;
    if (failures == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    #1 rst = 0;
    chk({td, 6'h0, ed}, 16'h0);
    foreach (rows[i]) begin
      {b, d, t, e} = rows[i];
      acc(OFS_DRIVE, b, 1, d);
      chk({td, 6'h0, ed}, {t, 6'h0, e});
      repeat (3) @(posedge clk);
      rdc(OFS_STATUS, 2'h3, st(e));
      rdc(OFS_DRIVE, 2'h3, {t, la});
    end
    ti = 1;
    ex = 2'h2;
    tx = 8'h01;
    repeat (4) @(posedge clk);
    rdc(OFS_STATUS, 2'h1, st(2'h2) & 16'h00ff);
    rdc(OFS_DRIVE, 2'h3, {8'hff, la});
    ti = 0;
    to = 1;
    repeat (4) @(posedge clk);
    rdc(OFS_STATUS, 2'h2, 16'hff00);
    rdc(OFS_STATUS, 2'h3, st(2'h2));
    acc(OFS_STATUS, 2'h3, 1, 16'h0001);
    rdc(6'h2a, 2'h3, 16'h0);
    srst = 1;
    repeat (2) @(posedge clk);
    #1 srst = 0;
    chk({td, 6'h0, ed}, 16'hff00);
    rst = 1;
    @(posedge clk) #1;
    chk({td, 6'h0, ed}, 16'h0);
    chk({15'h0, rv}, 16'h0);
    chk(rdat, 16'h0);
    rst = 0;
    repeat (3) @(posedge clk);
    rdc(OFS_STATUS, 2'h3, st(2'h2));
    @(posedge clk) #1;
    chk({15'h0, rv}, 16'h0);
    rdc(OFS_DRIVE, 2'h2, 16'h0100);
    rdc(OFS_DRIVE, 2'h1, {8'h00, la});
    acc(OFS_DRIVE, 2'h3, 1, 16'h8001);
    chk({td, 6'h0, ed}, 16'h8001);
    acc(OFS_DRIVE, 2'h3, 1, 16'h0000);
    chk({td, 6'h0, ed}, 16'h0);
    end_sim();
  end
endmodule

// ==== tb/trig_lines.sv ====
// Backplane trigger lines as seen by the block
`timescale 1ns/10ps
module trig_lines (
  input wire logic [7:0] ttl_drv,
  input wire logic [1:0] ecl_drv,
  input wire logic [7:0] ttl_ext,
  input wire logic [1:0] ecl_ext,
  output logic [7:0] ttl_st,
  output logic [1:0] ecl_st
);
  // Wired-or: this device or any other module asserts a line
  assign ttl_st = ttl_drv | ttl_ext;
  assign ecl_st = ecl_drv | ecl_ext;
endmodule
